// file: rtl/csrs_pkg.sv
package csrs_pkg;
    // Clock rate in kHz
    localparam int unsigned CLK_KHZ          = 50000;
    // Start-up delays
    localparam int unsigned START_SHORT_US   = 1000;
    localparam int unsigned START_LONG_US    = 16000;
    localparam int unsigned START_RC_US      = 16;
    localparam int unsigned START_SHORT_CYC  = START_SHORT_US * (CLK_KHZ / 1000);
    localparam int unsigned START_LONG_CYC   = START_LONG_US * (CLK_KHZ / 1000);
    localparam int unsigned START_RC_CYC     = START_RC_US * (CLK_KHZ / 1000);
    // Reset pin low qualification, system clock cycles
    localparam int unsigned RESET_MIN_CYC    = 2;
    // RC oscillator: 1 MHz nominal, half period in system clocks
    localparam int unsigned RC_FREQ_KHZ      = 1000;
    localparam int unsigned RC_HALF_CYC      = CLK_KHZ / (2 * RC_FREQ_KHZ);
    localparam int unsigned CNT_W            = 20;
    localparam int unsigned PORT_W           = 5;
    // Clock select fuse as delivered: programmed
    localparam logic        RC_FUSE_DEFAULT  = 1'b0;
    localparam logic        FUSE_PROGRAMMED  = 1'b0;
    localparam logic [4:0]  XTAL_IO_MASK     = 5'h07;
    localparam logic [4:0]  EXT_IO_MASK      = 5'h17;
    localparam logic [4:0]  RC_IO_MASK       = 5'h1f;
endpackage

// file: rtl/csrs_rc_osc.sv
`timescale 1ns/1ps
// Internal RC oscillator model, 1 MHz nominal, stops when disabled
module csrs_rc_osc (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic enable_i,
    output logic      rc_clk_o
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic       clk_q;
    logic       clk_d;

    always_comb begin
        cnt_d = cnt_q;
        clk_d = clk_q;
        if (!enable_i) begin
            cnt_d = 8'h00;
        end else if (cnt_q == 8'(csrs_pkg::RC_HALF_CYC - 1)) begin
            cnt_d = 8'h00;
            clk_d = ~clk_q;
        end else begin
            cnt_d = cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cnt_q <= 8'h00;
            clk_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            clk_q <= clk_d;
        end
    end

    assign rc_clk_o = clk_q;
endmodule

// file: rtl/csrs_top.sv
`timescale 1ns/1ps
module csrs_top (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        crystal_variant_i,
    input  wire logic        long_start_fuse_i,
    input  wire logic        rc_fuse_valid_i,
    input  wire logic        rc_clock_select_fuse,
    input  wire logic        reset_pin_n_i,
    input  wire logic        osc_amp_input,
    input  wire logic        idle_req_i,
    input  wire logic        powerdown_req_i,
    input  wire logic        wake_irq_i,
    input  wire logic [4:0]  port_dir_i,
    input  wire logic [4:0]  port_out_i,
    input  wire logic [4:0]  pullup_en_i,
    input  wire logic [4:0]  port_pin_i,
    output logic             osc_amp_output,
    output logic             sys_clk_o,
    output logic             cpu_clk_en_o,
    output logic             periph_clk_en_o,
    output logic             core_reset_o,
    output logic             rc_selected_o,
    output logic [4:0]       port_pin_o,
    output logic [4:0]       port_pin_oe_n_o,
    output logic [4:0]       pullup_on_o,
    output logic [4:0]       port_in_o,
    output logic [4:0]       io_avail_o
);
    typedef enum logic [1:0] {
        CSRS_RUN   = 2'b00,
        CSRS_IDLE  = 2'b01,
        CSRS_DOWN  = 2'b10,
        CSRS_START = 2'b11
    } csrs_state_e;

    csrs_state_e      state_q;
    csrs_state_e      state_d;
    logic [19:0]      cnt_q;
    logic [19:0]      cnt_d;
    logic [1:0]       rst_cnt_q;
    logic [1:0]       rst_cnt_d;
    logic             pin_rst_q;
    logic             pin_rst_d;
    logic             rc_sel_q;
    logic             rc_sel_d;
    logic             osc_run;
    logic             rc_clk;
    logic             src_clk;
    logic [19:0]      start_len;
    logic [4:0]       avail;
    logic             sys_clk_q;
    logic             cpu_en_q;
    logic             per_en_q;
    logic             core_rst_q;
    logic             amp_q;
    logic [4:0]       pin_o_q;
    logic [4:0]       oe_n_q;
    logic [4:0]       pu_q;
    logic [4:0]       in_q;
    logic [4:0]       avail_q;
    logic             wake_q;
    logic             wake_d;
    logic             sys_clk_d;
    logic             cpu_en_d;
    logic             per_en_d;
    logic             core_rst_d;
    logic             amp_d;
    logic [4:0]       pin_o_d;
    logic [4:0]       oe_n_d;
    logic [4:0]       pu_d;
    logic [4:0]       in_d;

    // Fuse reads as delivered until the fuse value is valid
    always_comb begin
        rc_sel_d = rc_sel_q;
        if (rc_fuse_valid_i) begin
            rc_sel_d = (rc_clock_select_fuse == csrs_pkg::FUSE_PROGRAMMED);
        end
    end

    assign osc_run = (state_q != CSRS_DOWN);

    csrs_rc_osc u_rc (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .enable_i (osc_run && rc_sel_q && !crystal_variant_i),
        .rc_clk_o (rc_clk)
    );

    // Clock source mux
    always_comb begin
        if (crystal_variant_i) begin
            src_clk = osc_amp_input;
        end else if (rc_sel_q) begin
            src_clk = rc_clk;
        end else begin
            src_clk = port_pin_i[3];
        end
    end

    // Start-up length
    always_comb begin
        if (crystal_variant_i) begin
            start_len = long_start_fuse_i ? 20'(csrs_pkg::START_LONG_CYC)
                                          : 20'(csrs_pkg::START_SHORT_CYC);
        end else begin
            start_len = 20'(csrs_pkg::START_RC_CYC);
        end
    end

    // I/O availability by variant and source
    always_comb begin
        if (crystal_variant_i) begin
            avail = csrs_pkg::XTAL_IO_MASK;
        end else if (rc_sel_q) begin
            avail = csrs_pkg::RC_IO_MASK;
        end else begin
            avail = csrs_pkg::EXT_IO_MASK;
        end
    end

    // Reset pin qualification, counted while oscillator runs
    always_comb begin
        rst_cnt_d = rst_cnt_q;
        pin_rst_d = 1'b0;
        if (reset_pin_n_i) begin
            rst_cnt_d = 2'h0;
        end else if (osc_run) begin
            if (rst_cnt_q < 2'(csrs_pkg::RESET_MIN_CYC)) begin
                rst_cnt_d = rst_cnt_q + 2'h1;
            end
            pin_rst_d = (rst_cnt_q >= 2'(csrs_pkg::RESET_MIN_CYC - 1));
        end
    end

    // Power state machine
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        wake_d  = wake_q;
        case (state_q)
            CSRS_START: begin
                if (cnt_q >= start_len - 20'h1) begin
                    state_d = CSRS_RUN;
                    cnt_d   = 20'h0;
                    wake_d  = 1'b0;
                end else begin
                    cnt_d = cnt_q + 20'h1;
                end
            end
            CSRS_RUN: begin
                if (powerdown_req_i) begin
                    state_d = CSRS_DOWN;
                end else if (idle_req_i) begin
                    state_d = CSRS_IDLE;
                end
            end
            CSRS_IDLE: begin
                if (wake_irq_i) begin
                    state_d = CSRS_RUN;
                end
            end
            CSRS_DOWN: begin
                if (wake_irq_i) begin
                    state_d = CSRS_START;
                    cnt_d   = 20'h0;
                    wake_d  = 1'b1;
                end
            end
            default: begin
                state_d = CSRS_START;
            end
        endcase
        if (pin_rst_q) begin
            state_d = CSRS_START;
            cnt_d   = 20'h0;
            wake_d  = 1'b0;
        end
    end

    // Output register next values
    always_comb begin
        sys_clk_d  = osc_run ? src_clk : 1'b0;
        cpu_en_d   = (state_d == CSRS_RUN);
        per_en_d   = (state_d == CSRS_RUN) || (state_d == CSRS_IDLE);
        core_rst_d = (state_d == CSRS_START) && !wake_d;
        amp_d      = (crystal_variant_i && osc_run) ? ~osc_amp_input : 1'b1;
        pin_o_d    = port_out_i & avail;
        oe_n_d     = ~(port_dir_i & avail);
        pu_d       = pullup_en_i & ~port_dir_i & avail;
        in_d       = port_pin_i & avail;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_q    <= CSRS_START;
            cnt_q      <= 20'h0;
            rst_cnt_q  <= 2'h0;
            pin_rst_q  <= 1'b0;
            rc_sel_q   <= (csrs_pkg::RC_FUSE_DEFAULT == csrs_pkg::FUSE_PROGRAMMED);
            wake_q     <= 1'b0;
            sys_clk_q  <= 1'b0;
            cpu_en_q   <= 1'b0;
            per_en_q   <= 1'b0;
            core_rst_q <= 1'b1;
            amp_q      <= 1'b1;
            pin_o_q    <= 5'h00;
            oe_n_q     <= 5'h1f;
            pu_q       <= 5'h00;
            in_q       <= 5'h00;
            avail_q    <= 5'h00;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            rst_cnt_q  <= rst_cnt_d;
            pin_rst_q  <= pin_rst_d;
            rc_sel_q   <= rc_sel_d;
            wake_q     <= wake_d;
            sys_clk_q  <= sys_clk_d;
            cpu_en_q   <= cpu_en_d;
            per_en_q   <= per_en_d;
            core_rst_q <= core_rst_d;
            amp_q      <= amp_d;
            pin_o_q    <= pin_o_d;
            oe_n_q     <= oe_n_d;
            pu_q       <= pu_d;
            in_q       <= in_d;
            avail_q    <= avail;
        end
    end

    assign osc_amp_output  = amp_q;
    assign sys_clk_o       = sys_clk_q;
    assign cpu_clk_en_o    = cpu_en_q;
    assign periph_clk_en_o = per_en_q;
    assign core_reset_o    = core_rst_q;
    assign rc_selected_o   = rc_sel_q;
    assign port_pin_o      = pin_o_q;
    assign port_pin_oe_n_o = oe_n_q;
    assign pullup_on_o     = pu_q;
    assign port_in_o       = in_q;
    assign io_avail_o      = avail_q;

    start_delay_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (state_q == CSRS_START) |-> ##1 (state_q inside {CSRS_START, CSRS_RUN}))
        else $error("start state left wrongly");
    pin_reset_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (!reset_pin_n_i && osc_run) [*3] |=> (state_q == CSRS_START))
        else $error("reset pin not honoured");
    pin_rst_core_a: assert property (@(posedge clk_i) disable iff (reset_i)
        pin_rst_q |=> core_rst_q)
        else $error("pin reset leaves core running");
    xtal_io_a: assert property (@(posedge clk_i) disable iff (reset_i)
        crystal_variant_i |=> (oe_n_q[4:3] == 2'b11))
        else $error("crystal pins driven as io");
    ext_clk_io_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (!crystal_variant_i && !rc_sel_q) |=> oe_n_q[3])
        else $error("clock input driven as io");
    bit4_io_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !crystal_variant_i |=> avail_q[4])
        else $error("bit 4 not available");
    idle_cpu_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (state_q == CSRS_IDLE) |-> (!cpu_en_q && per_en_q) || $changed(state_q))
        else $error("idle gating wrong");
    down_clk_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (state_q == CSRS_DOWN) [*2] |-> !sys_clk_q)
        else $error("clock runs in power down");
    wake_keep_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (state_q == CSRS_DOWN && wake_irq_i && !pin_rst_q) |=> !core_rst_q)
        else $error("wake from power down resets core");
    rc_start_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !crystal_variant_i |-> (start_len == 20'(csrs_pkg::START_RC_CYC)))
        else $error("rc start length wrong");
    fuse_sel_a: assert property (@(posedge clk_i) disable iff (reset_i)
        rc_fuse_valid_i |=> (rc_sel_q == !$past(rc_clock_select_fuse)))
        else $error("fuse select wrong");
    xtal_start_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (crystal_variant_i && !long_start_fuse_i)
        |-> (start_len == 20'(csrs_pkg::START_SHORT_CYC)))
        else $error("short start length wrong");
    xtal_long_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (crystal_variant_i && long_start_fuse_i)
        |-> (start_len == 20'(csrs_pkg::START_LONG_CYC)))
        else $error("long start length wrong");

    idle_c: cover property (@(posedge clk_i) state_q == CSRS_IDLE);
    down_c: cover property (@(posedge clk_i) state_q == CSRS_DOWN ##1 state_q == CSRS_START);
    pinrst_c: cover property (@(posedge clk_i) pin_rst_q);
    wake_c: cover property (@(posedge clk_i) state_q == CSRS_IDLE ##1 state_q == CSRS_RUN);
    xtal_run_c: cover property (@(posedge clk_i) crystal_variant_i && state_q == CSRS_RUN);
endmodule

// file: sim/clock_source_reset_startup_test.sv
`timescale 1ns/1ps
module clock_source_reset_startup_test;
    typedef struct {int id; logic [4:0] v;} csrs_exp_s;
    logic       clk_i = 1'b0;
    logic       reset_i = 1'b1;
    logic       xtal_v = 1'b0;
    logic       long_f = 1'b0;
    logic       fuse_v = 1'b0;
    logic       fuse = 1'b1;
    logic       rst_n = 1'b1;
    logic       idle_r = 1'b0;
    logic       pd_r = 1'b0;
    logic       wake = 1'b0;
    logic       xrun = 1'b0;
    logic       erun = 1'b0;
    logic [4:0] dir = 5'h00;
    logic [4:0] dout = 5'h00;
    logic [4:0] pu = 5'h00;
    logic [4:0] pin_r = 5'h00;
    logic       osc, eclk, amp_o, sclk, cpu_en, per_en, core_rst, rc_sel;
    logic [4:0] pin_o, oe_n, pu_on, pin_in, avail, pin_i;
    int         err_total = 0;
    int         total_checks = 0;
    int         seed = 55;
    int         cyc = 0;
    int         rises = 0;
    csrs_exp_s  q[$];
    event       smp;
    string      nm[11] = '{"core_reset", "rc_sel", "io_avail", "cpu_en", "periph_en",
                           "oe_n", "pullup", "pin_out", "pin_in", "clk_rises", "amp_out"};

    assign pin_i = {pin_r[4], erun ? eclk : pin_r[3], pin_r[2:0]};

    csrs_clk_source i_src (.clk_i(clk_i), .xtal_run_i(xrun), .ext_run_i(erun),
        .osc_o(osc), .ext_clk_o(eclk));

    csrs_top i_dut (.clk_i(clk_i), .reset_i(reset_i), .crystal_variant_i(xtal_v),
        .long_start_fuse_i(long_f), .rc_fuse_valid_i(fuse_v),
        .rc_clock_select_fuse(fuse), .reset_pin_n_i(rst_n), .osc_amp_input(osc),
        .idle_req_i(idle_r), .powerdown_req_i(pd_r), .wake_irq_i(wake),
        .port_dir_i(dir), .port_out_i(dout), .pullup_en_i(pu), .port_pin_i(pin_i),
        .osc_amp_output(amp_o), .sys_clk_o(sclk), .cpu_clk_en_o(cpu_en),
        .periph_clk_en_o(per_en), .core_reset_o(core_rst), .rc_selected_o(rc_sel),
        .port_pin_o(pin_o), .port_pin_oe_n_o(oe_n), .pullup_on_o(pu_on),
        .port_in_o(pin_in), .io_avail_o(avail));

    initial begin
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge sclk) rises <= rises + 1;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 70000) begin
            err_total++;
            test_done();
        end
    end

    function automatic logic [4:0] obs(input int id);
        case (id)
            0: return {4'h0, core_rst};
            1: return {4'h0, rc_sel};
            2: return avail;
            3: return {4'h0, cpu_en};
            4: return {4'h0, per_en};
            5: return oe_n;
            6: return pu_on;
            7: return pin_o;
            8: return pin_in;
            9: return rises[4:0];
            default: return {4'h0, amp_o};
        endcase
    endfunction

    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic cyc_n(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic chk(input int id, input logic [4:0] v);
        q.push_back('{id, v});
        -> smp;
    endtask

    task automatic do_reset(input logic xv, input logic fv, input logic f);
        xtal_v = xv;
        fuse_v = fv;
        fuse = f;
        reset_i = 1'b1;
        cyc_n(10);
        reset_i = 1'b0;
    endtask

    task automatic chk_start(input int len);
        cyc_n(len - 10);
        chk(0, 5'h01);
        cyc_n(20);
        chk(0, 5'h00);
    endtask

    task automatic port_chk(input logic [4:0] m);
        for (int i = 0; i < 4; i++) begin
            dir = i[0] ? 5'h1f : 5'h00;
            dout = 5'($random(seed));
            pu = 5'($random(seed));
            pin_r = 5'($random(seed));
            cyc_n(2);
            chk(2, m);
            chk(5, ~(dir & m));
            chk(8, pin_i & m);
            if (i[0]) chk(7, dout & m);
            else chk(6, pu & m);
        end
    endtask

    initial begin
        csrs_exp_s  e;
        logic [4:0] got;
        forever begin
            @(smp);
            while (q.size() > 0) begin
                e = q.pop_front();
                got = obs(e.id);
                total_checks++;
                if (got !== e.v) begin
                    err_total++;
                    $display("wrong value %s expected %h seen %h", nm[e.id], e.v, got);
                end
            end
        end
    end

    initial begin
        do_reset(1'b0, 1'b0, 1'b1);
        chk_start(csrs_pkg::START_RC_CYC);
        chk(1, 5'h01);
        port_chk(5'h1f);
        rises = 0;
        cyc_n(250);
        chk(9, 5'h05);
        idle_r = 1'b1;
        cyc_n(3);
        chk(3, 5'h00);
        chk(4, 5'h01);
        idle_r = 1'b0;
        wake = 1'b1;
        cyc_n(1);
        wake = 1'b0;
        cyc_n(3);
        chk(3, 5'h01);
        pd_r = 1'b1;
        cyc_n(3);
        pd_r = 1'b0;
        chk(4, 5'h00);
        rises = 0;
        cyc_n(100);
        chk(9, 5'h00);
        wake = 1'b1;
        cyc_n(1);
        wake = 1'b0;
        cyc_n(3);
        chk(0, 5'h00);
        chk(3, 5'h00);
        cyc_n(csrs_pkg::START_RC_CYC + 20);
        chk(3, 5'h01);
        rst_n = 1'b0;
        cyc_n(1);
        rst_n = 1'b1;
        cyc_n(3);
        chk(0, 5'h00);
        rst_n = 1'b0;
        cyc_n(2);
        rst_n = 1'b1;
        cyc_n(2);
        chk(0, 5'h01);
        cyc_n(csrs_pkg::START_RC_CYC + 20);
        chk(0, 5'h00);
        erun = 1'b1;
        do_reset(1'b0, 1'b1, 1'b1);
        chk_start(csrs_pkg::START_RC_CYC);
        chk(1, 5'h00);
        port_chk(5'h17);
        rises = 0;
        cyc_n(200);
        chk(9, 5'h14);
        erun = 1'b0;
        do_reset(1'b0, 1'b1, 1'b0);
        chk_start(csrs_pkg::START_RC_CYC);
        chk(1, 5'h01);
        xrun = 1'b1;
        do_reset(1'b1, 1'b1, 1'b1);
        chk_start(csrs_pkg::START_SHORT_CYC);
        port_chk(5'h07);
        long_f = 1'b1;
        rises = 0;
        cyc_n(200);
        chk(9, 5'h19);
        xrun = 1'b0;
        cyc_n(3);
        chk(10, {4'h0, ~osc});
        xrun = 1'b1;
        cyc_n(4);
        xrun = 1'b0;
        cyc_n(3);
        chk(10, {4'h0, ~osc});
        #1;
        test_done();
    end
endmodule

// file: sim/csrs_clk_source.sv
`timescale 1ns/1ps
// Crystal on pin one and external clock for port bit 3; both freeze when stopped
module csrs_clk_source #(
    parameter int XTAL_HALF = 4,
    parameter int EXT_HALF  = 5
) (
    input  wire logic clk_i,
    input  wire logic xtal_run_i,
    input  wire logic ext_run_i,
    output logic      osc_o,
    output logic      ext_clk_o
);
    int xc = 0;
    int ec = 0;
    initial osc_o = 1'b0;
    initial ext_clk_o = 1'b0;
    // Swing on crystal pin one
    always @(posedge clk_i) begin
        if (xtal_run_i) begin
            xc = (xc + 1) % XTAL_HALF;
            if (xc == 0) osc_o <= #1 ~osc_o;
        end
    end
    // Clock into port bit 3
    always @(posedge clk_i) begin
        if (ext_run_i) begin
            ec = (ec + 1) % EXT_HALF;
            if (ec == 0) ext_clk_o <= #1 ~ext_clk_o;
        end
    end
endmodule
